// [src/scs_defs.svh]
// constants of the system clock switch: register layout, divider ratios,
// switch delays and start-up timing. included by the design files.
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// register layout
`define SCS_REG_W        4
`define SCS_RESET_VAL    4'h0
`define SCS_SEL_BIT      0
`define SCS_STOP_BIT     3
`define SCS_READ_MASK    4'h9

// machine cycle length in source ticks
`define SCS_CNT_W        7
`define SCS_DIV_CODE0    7'h40
`define SCS_DIV_CODE1    7'h10
`define SCS_DIV_CODE2    7'h08
`define SCS_DIV_CODE3    7'h04
`define SCS_DIV_SUB      7'h04

// divider codes of the low two divider bits
`define SCS_CODE0        2'h0
`define SCS_CODE1        2'h1
`define SCS_CODE2        2'h2
`define SCS_CODE3        2'h3

// machine cycles of the previous clock before a change takes effect
`define SCS_DLY_W        5
`define SCS_DLY_CODE0    5'h01
`define SCS_DLY_CODE1    5'h04
`define SCS_DLY_CODE2    5'h08
`define SCS_DLY_CODE3    5'h10
`define SCS_DLY_SUB      5'h01

// oscillation stabilisation after reset
`define SCS_OSC_WAIT_NS  21800000
`define SCS_CLK_NS       25

`endif

// [src/scs_pkg.sv]
// types shared by the system clock switch files.
// assumes nothing of its surroundings.
`default_nettype none

package scs_pkg;
	typedef enum logic [1:0] {
		SCS_ST_WAIT,
		SCS_ST_RUN,
		SCS_ST_DELAY,
		SCS_ST_SYNC
	} scs_state_t;
endpackage

`default_nettype wire

// [src/scs_cycle_gen.sv]
// machine cycle generator: counts source clock ticks and pulses once per
// machine cycle. assumes tick_i is a one-cycle enable on sys_clk_i.
`include "scs_defs.svh"
`default_nettype none

module scs_cycle_gen #(
	parameter int CNT_W = `SCS_CNT_W
) (
	input  wire logic             sys_clk_i,
	input  wire logic             resetn_i,
	input  wire logic             tick_i,
	input  wire logic             restart_i,
	input  wire logic [CNT_W-1:0] div_i,
	output logic                  cycle_o
);
	logic [CNT_W-1:0] count;

	// refuse a counter too narrow for the longest machine cycle
	if (CNT_W < `SCS_CNT_W)
	begin : g_cnt_w_check
		$error("scs_cycle_gen: counter too narrow for divider ratios");
	end

	// tick counter, wraps at the divider ratio
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			count <= '0;
		else if (restart_i)
			count <= '0;
		else if (tick_i)
		begin
			if (count >= div_i - CNT_W'(1))
				count <= '0;
			else
				count <= count + CNT_W'(1);
		end
	end

	// one pulse at the last tick of each machine cycle
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cycle_o <= 1'b0;
		else
			cycle_o <= tick_i && !restart_i && (count >= div_i - CNT_W'(1));
	end
endmodule

`default_nettype wire

// [src/scs_clock_switch.sv]
// system clock switch control: clock select register, cpu clock source
// switching with documented delays, main oscillator gating, stop gating.
// assumes oscillator edges arrive as one-cycle ticks synchronous to
// sys_clk_i, and that the divider register is held outside this block.
//
// Summary of operation
// - four-bit register, bit0 subclock, bit3 oscillator stop
// - only one control bit may change per write
// - bit access works regardless of bank enable
// - stop bit halts oscillator only on subclock
// - reset clears register, main clock running
// - stop bit on main clock is no stop
// - stop bit one grounds oscillator input pin
// - previous clock runs some cycles after change
// - divider change delay 1/4/8/16, leaving subclock 1
// - main to subclock waits for subclock boundary
// - machine cycle equals one selected cpu clock period
// - wait oscillator stabilisation, start slowest main setting
// - subclock ignores divider bits, runs subclock/4
// - stop instruction accepted only on main clock
`include "scs_defs.svh"
`default_nettype none

module scs_clock_switch #(
	parameter int OSC_WAIT_CYCLES = (`SCS_OSC_WAIT_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS
) (
	input  wire logic                  sys_clk_i,
	input  wire logic                  resetn_i,
	input  wire logic                  main_osc_tick_i,
	input  wire logic                  sub_osc_tick_i,
	input  wire logic                  bit_wr_i,
	input  wire logic [1:0]            bit_idx_i,
	input  wire logic                  bit_val_i,
	input  wire logic                  nib_wr_i,
	input  wire logic [`SCS_REG_W-1:0] nib_data_i,
	input  wire logic [3:0]            cpu_clock_divider_reg_i,
	input  wire logic                  stop_req_i,
	output logic [`SCS_REG_W-1:0]      system_clock_select_o,
	output logic                       cpu_cycle_o,
	output logic                       cpu_run_o,
	output logic                       sub_active_o,
	output logic [1:0]                 active_code_o,
	output logic                       main_osc_run_o,
	output logic                       main_osc_input_pin_gnd_o,
	output logic                       stop_accept_o
);
	localparam int WAIT_W = $clog2(OSC_WAIT_CYCLES + 1);

	scs_pkg::scs_state_t          state;
	logic [`SCS_REG_W-1:0]        system_clock_select;
	logic [WAIT_W-1:0]            wait_count;
	logic [`SCS_DLY_W-1:0]        dly_count;
	logic                         act_sub;
	logic [1:0]                   act_code;
	logic                         tgt_sub;
	logic [1:0]                   tgt_code;
	logic                         restart;
	logic                         main_cycle;
	logic                         sub_cycle;
	logic                         cur_cycle;
	logic                         main_tick;
	logic                         change_req;
	logic                         nib_ok;
	logic [`SCS_CNT_W-1:0]        main_div;
	logic [`SCS_DLY_W-1:0]        next_dly;

	// refuse a start-up wait that the counter cannot serve
	if (OSC_WAIT_CYCLES < 1)
	begin : g_wait_check
		$error("scs_clock_switch: oscillator wait must be at least one cycle");
	end

	// a stopped oscillator delivers no ticks
	assign main_tick = main_osc_tick_i && main_osc_run_o;
	// machine cycle of whichever source is currently applied
	assign cur_cycle = act_sub ? sub_cycle : main_cycle;
	// a nibble write may change at most one of the two control bits
	assign nib_ok = !((nib_data_i[`SCS_SEL_BIT] != system_clock_select[`SCS_SEL_BIT]) &&
		(nib_data_i[`SCS_STOP_BIT] != system_clock_select[`SCS_STOP_BIT]));
	assign change_req = (system_clock_select[`SCS_SEL_BIT] != act_sub) ||
		(!act_sub && (cpu_clock_divider_reg_i[1:0] != act_code));

	// main machine cycle ratio from the applied divider code
	always_comb
	begin
		case (act_code)
			`SCS_CODE0: main_div = `SCS_DIV_CODE0;
			`SCS_CODE1: main_div = `SCS_DIV_CODE1;
			`SCS_CODE2: main_div = `SCS_DIV_CODE2;
			default:    main_div = `SCS_DIV_CODE3;
		endcase
	end

	// cycles of the previous clock that run before a change
	always_comb
	begin
		if (act_sub)
			next_dly = `SCS_DLY_SUB;
		else
		begin
			case (act_code)
				`SCS_CODE0: next_dly = `SCS_DLY_CODE0;
				`SCS_CODE1: next_dly = `SCS_DLY_CODE1;
				`SCS_CODE2: next_dly = `SCS_DLY_CODE2;
				default:    next_dly = `SCS_DLY_CODE3;
			endcase
		end
	end

	scs_cycle_gen #(
		.CNT_W(`SCS_CNT_W)
	) u_main_gen (
		.sys_clk_i(sys_clk_i),
		.resetn_i (resetn_i),
		.tick_i   (main_tick),
		.restart_i(restart),
		.div_i    (main_div),
		.cycle_o  (main_cycle)
	);

	scs_cycle_gen #(
		.CNT_W(`SCS_CNT_W)
	) u_sub_gen (
		.sys_clk_i(sys_clk_i),
		.resetn_i (resetn_i),
		.tick_i   (sub_osc_tick_i),
		.restart_i(restart),
		.div_i    (`SCS_DIV_SUB),
		.cycle_o  (sub_cycle)
	);

	// control register; bank enable takes no part in the decode
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			system_clock_select <= `SCS_RESET_VAL;
		else if (bit_wr_i)
		begin
			if (bit_idx_i == 2'(`SCS_SEL_BIT))
				system_clock_select[`SCS_SEL_BIT] <= bit_val_i;
			else if (bit_idx_i == 2'(`SCS_STOP_BIT))
				system_clock_select[`SCS_STOP_BIT] <= bit_val_i;
		end
		else if (nib_wr_i && nib_ok)
			system_clock_select <= nib_data_i & `SCS_READ_MASK;
	end

	// source switching sequencer
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state      <= scs_pkg::SCS_ST_WAIT;
			wait_count <= '0;
			dly_count  <= '0;
			act_sub    <= 1'b0;
			act_code   <= `SCS_CODE0;
			tgt_sub    <= 1'b0;
			tgt_code   <= `SCS_CODE0;
			restart    <= 1'b1;
		end
		else
		begin
			restart <= 1'b0;
			case (state)
				scs_pkg::SCS_ST_WAIT:
				begin
					// start at the slowest main setting once stable
					if (wait_count == WAIT_W'(OSC_WAIT_CYCLES - 1))
					begin
						state    <= scs_pkg::SCS_ST_RUN;
						act_code <= `SCS_CODE0;
						restart  <= 1'b1;
					end
					else
						wait_count <= wait_count + WAIT_W'(1);
				end
				scs_pkg::SCS_ST_RUN:
				begin
					if (change_req)
					begin
						state     <= scs_pkg::SCS_ST_DELAY;
						dly_count <= next_dly;
						tgt_sub   <= system_clock_select[`SCS_SEL_BIT];
						tgt_code  <= cpu_clock_divider_reg_i[1:0];
					end
				end
				scs_pkg::SCS_ST_DELAY:
				begin
					// old clock keeps running until the delay ends
					if (cur_cycle)
					begin
						if (dly_count == `SCS_DLY_W'(1))
						begin
							if (tgt_sub && !act_sub)
								state <= scs_pkg::SCS_ST_SYNC;
							else
							begin
								state    <= scs_pkg::SCS_ST_RUN;
								act_sub  <= tgt_sub;
								act_code <= tgt_code;
								restart  <= 1'b1;
							end
						end
						else
							dly_count <= dly_count - `SCS_DLY_W'(1);
					end
				end
				scs_pkg::SCS_ST_SYNC:
				begin
					// hand over on a subclock edge that meets a main cycle end, or on any subclock edge on divider code 3
					if (sub_osc_tick_i && (main_cycle || main_div == `SCS_DIV_CODE3))
					begin
						state   <= scs_pkg::SCS_ST_RUN;
						act_sub <= 1'b1;
						restart <= 1'b1;
					end
				end
				default:
					state <= scs_pkg::SCS_ST_WAIT;
			endcase
		end
	end

	// registered outputs
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			system_clock_select_o    <= `SCS_RESET_VAL;
			cpu_cycle_o              <= 1'b0;
			cpu_run_o                <= 1'b0;
			sub_active_o             <= 1'b0;
			active_code_o            <= `SCS_CODE0;
			main_osc_run_o           <= 1'b1;
			main_osc_input_pin_gnd_o <= 1'b0;
			stop_accept_o            <= 1'b0;
		end
		else
		begin
			system_clock_select_o <= system_clock_select & `SCS_READ_MASK;
			cpu_cycle_o           <= (state != scs_pkg::SCS_ST_WAIT) && cur_cycle && !restart;
			cpu_run_o             <= (state != scs_pkg::SCS_ST_WAIT);
			sub_active_o          <= act_sub;
			active_code_o         <= act_code;
			// stop bit halts generation only once on the subclock
			main_osc_run_o <= !(system_clock_select[`SCS_STOP_BIT] && act_sub);
			main_osc_input_pin_gnd_o <= system_clock_select[`SCS_STOP_BIT];
			stop_accept_o <= stop_req_i && !act_sub && (state != scs_pkg::SCS_ST_WAIT);
		end
	end
endmodule

`default_nettype wire

// [test/scs_clock_switch_asserts.sv]
// port checker of the system clock switch: register, gating, stop, start-up
// bound to every scs_clock_switch below; sees that module's ports only
`default_nettype none

module scs_clock_switch_asserts #(
	parameter int OSC_WAIT_CYCLES = 8
) (
	input wire logic       sys_clk_i,
	input wire logic       resetn_i,
	input wire logic       bit_wr_i,
	input wire logic [1:0] bit_idx_i,
	input wire logic       bit_val_i,
	input wire logic       stop_req_i,
	input wire logic [3:0] system_clock_select_o,
	input wire logic       cpu_cycle_o,
	input wire logic       cpu_run_o,
	input wire logic       sub_active_o,
	input wire logic [1:0] active_code_o,
	input wire logic       main_osc_run_o,
	input wire logic       main_osc_input_pin_gnd_o,
	input wire logic       stop_accept_o
);
	int n_edge;

	// edges since reset release, saturating just past the start-up wait
	always_ff @(posedge sys_clk_i or negedge resetn_i)
		if (!resetn_i)
			n_edge <= 0;
		else if (n_edge <= OSC_WAIT_CYCLES)
			n_edge <= n_edge + 1;

	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);

	property p_pad; system_clock_select_o[2:1] == 2'h0; endproperty
	property p_bit;
		bit_wr_i && (bit_idx_i == 2'h0 || bit_idx_i == 2'h3) |-> ##2
			system_clock_select_o[$past(bit_idx_i, 2)] == $past(bit_val_i, 2);
	endproperty
	property p_idx;
		bit_wr_i && bit_idx_i inside {2'h1, 2'h2} |=> ##1 $stable(system_clock_select_o);
	endproperty
	property p_osc_on; (!system_clock_select_o[3]) [*2] |-> main_osc_run_o; endproperty
	property p_osc_off;
		(sub_active_o && system_clock_select_o[3]) [*3] |-> !main_osc_run_o;
	endproperty
	property p_gnd;
		$rose(system_clock_select_o[3]) |->
			main_osc_input_pin_gnd_o || $past(main_osc_input_pin_gnd_o);
	endproperty
	property p_acc; stop_accept_o |-> $past(stop_req_i) && cpu_run_o; endproperty
	property p_noacc; stop_req_i && sub_active_o ##1 sub_active_o |-> !stop_accept_o; endproperty
	property p_gap; cpu_cycle_o |=> !cpu_cycle_o [*3]; endproperty
	property p_start;
		$rose(cpu_run_o) |->
			n_edge == OSC_WAIT_CYCLES + 1 && active_code_o == 2'h0 && !sub_active_o;
	endproperty

	a_pad: assert property (p_pad) else $error("pad bits set");
	a_bit: assert property (p_bit) else $error("bit write lost");
	a_idx: assert property (p_idx) else $error("bad index wrote");
	a_osc_on: assert property (p_osc_on) else $error("osc stopped");
	a_osc_off: assert property (p_osc_off) else $error("osc not stopped");
	a_gnd: assert property (p_gnd) else $error("pin not grounded");
	a_acc: assert property (p_acc) else $error("stray stop accept");
	a_noacc: assert property (p_noacc) else $error("stop on subclock");
	a_gap: assert property (p_gap) else $error("short cycle");
	a_start: assert property (p_start) else $error("bad start");

	c_sub: cover property ($rose(sub_active_o));
	c_off: cover property ($fell(main_osc_run_o));
	c_acc: cover property (stop_accept_o);
endmodule

bind scs_clock_switch scs_clock_switch_asserts #(
	.OSC_WAIT_CYCLES(OSC_WAIT_CYCLES)
) u_chk (.*);

`default_nettype wire

// [test/scs_clock_switch_tb_top.sv]
// bench of the system clock switch: random register traffic and corner cases
// assumes the checker binds itself; oscillator ticks are random pulses
`default_nettype none

module scs_clock_switch_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic       sys_clk_i = '0, resetn_i = '0, main_osc_tick_i = '0, sub_osc_tick_i = '0;
	logic       bit_wr_i = '0, bit_val_i = '0, nib_wr_i = '0, stop_req_i = '0;
	logic [1:0] bit_idx_i = '0;
	logic [3:0] nib_data_i = '0, cpu_clock_divider_reg_i = '0, m;
	logic [3:0] system_clock_select_o;
	logic [1:0] active_code_o;
	logic       cpu_cycle_o, cpu_run_o, sub_active_o, main_osc_run_o;
	logic       main_osc_input_pin_gnd_o, stop_accept_o;
	int         n_fail = 0, n_tests = 0, p, k;

	scs_clock_switch #(.OSC_WAIT_CYCLES(8)) uut (.*);

	// free-running system clock
	always #12.5 sys_clk_i = ~sys_clk_i;

	// random oscillator ticks, subclock ones sparser
	always @(posedge sys_clk_i)
	begin
		main_osc_tick_i <= 1'($urandom % 2);
		sub_osc_tick_i <= ($urandom % 8) == 0;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// expected register after one write; nibble changing both bits is dropped
	function automatic logic [3:0] nxt(input logic [3:0] r, input logic b,
			input logic [1:0] i, input logic v, input logic [3:0] d);
		if (!b)
			return (d[0] != r[0] && d[3] != r[3]) ? r : {d[3], 2'h0, d[0]};
		if (i == 2'h0)
			r[0] = v;
		if (i == 2'h3)
			r[3] = v;
		return r;
	endfunction

	task automatic rst;
		@(posedge sys_clk_i);
		resetn_i <= 1'h0;
		repeat (8) @(posedge sys_clk_i);
		resetn_i <= 1'h1;
		m = 4'h0;
		#1 chk(8'(system_clock_select_o), 8'h0);
	endtask

	task automatic wr(input logic b, input logic [1:0] i, input logic v, input logic [3:0] d);
		@(posedge sys_clk_i);
		bit_wr_i <= b;
		nib_wr_i <= !b;
		bit_idx_i <= i;
		bit_val_i <= v;
		nib_data_i <= d;
		@(posedge sys_clk_i);
		bit_wr_i <= 1'h0;
		nib_wr_i <= 1'h0;
		m = nxt(m, b, i, v, d);
		repeat (2) @(posedge sys_clk_i);
		#1 chk(8'(system_clock_select_o), 8'(m));
	endtask

	task automatic stp(input logic e);
		@(posedge sys_clk_i);
		stop_req_i <= 1'h1;
		@(posedge sys_clk_i);
		stop_req_i <= 1'h0;
		#1 chk(8'(stop_accept_o), 8'(e));
	endtask

	// change divider code, count old-clock cycles until it is applied
	task automatic sw(input logic [1:0] c);
		@(posedge sys_clk_i);
		cpu_clock_divider_reg_i <= {2'h0, c};
		p = 0;
		k = 0;
		// a pulse already showing when the request lands is not part of the delay
		@(posedge sys_clk_i);
		while (active_code_o !== c && k < 9000)
		begin
			@(posedge sys_clk_i);
			#1 p += int'(cpu_cycle_o);
			k++;
		end
	endtask

	task automatic wsub(input logic v);
		k = 0;
		while (sub_active_o !== v && k < 9000)
		begin
			@(posedge sys_clk_i);
			#1 k++;
		end
		chk(8'(sub_active_o), 8'(v));
	endtask

	// main sequence
	initial
	begin
		void'($urandom(32'h4e7d));
		rst();
		chk(8'(main_osc_run_o), 8'h1);
		repeat (8) @(posedge sys_clk_i);
		#1 chk(8'(cpu_run_o), 8'h0);
		repeat (2) @(posedge sys_clk_i);
		#1 chk(8'({cpu_run_o, sub_active_o, active_code_o}), 8'h8);
		for (int o = 0; o < 4; o++)
		begin
			sw(2'(o));
			sw(2'(o) ^ 2'h1);
			chk(8'(p), 8'(o == 0 ? 1 : 2 << o));
		end
		stp(1'h1);
		repeat (40)
		begin
			k = $urandom % 4;
			wr(1'($urandom % 2), 2'(k), k == 3 ? 1'h0 : 1'($urandom % 2), 4'($urandom % 8));
			wsub(m[0]);
		end
		wr(1'h1, 2'h0, 1'h0, 4'h0);
		wsub(1'h0);
		wr(1'h1, 2'h0, 1'h1, 4'h0);
		wsub(1'h1);
		@(posedge sys_clk_i) cpu_clock_divider_reg_i <= 4'h3;
		k = 0;
		while (k < 32)
		begin
			@(posedge sys_clk_i);
			#1 k += int'(cpu_cycle_o);
		end
		chk(8'({main_osc_run_o, active_code_o}), 8'h6);
		wr(1'h1, 2'h3, 1'h1, 4'h0);
		repeat (3) @(posedge sys_clk_i);
		#1 chk(8'({main_osc_run_o, main_osc_input_pin_gnd_o}), 8'h1);
		stp(1'h0);
		wr(1'h0, 2'h0, 1'h0, 4'h0);
		wr(1'h1, 2'h3, 1'h0, 4'h0);
		repeat (3) @(posedge sys_clk_i);
		#1 chk(8'({main_osc_run_o, main_osc_input_pin_gnd_o}), 8'h2);
		wr(1'h1, 2'h0, 1'h0, 4'h0);
		wsub(1'h0);
		rst();
		tally_and_finish();
	end

	// watchdog against a hung wait
	initial
	begin
		#2000000;
		n_fail++;
		tally_and_finish();
	end
endmodule

`default_nettype wire
